// file: core/clock_reset_pkg.sv
package clock_reset_pkg;

  // Divider: two oscillator periods low, two high per bus-phase period
  localparam int unsigned OSC_PER_BUS     = 4;
  localparam int unsigned BUS_LOW_COUNT   = 2;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;
  localparam logic [1:0]  PHASE_HIGH_FROM = 2'h2;
  // Reset pin classification window, in bus-phase cycles
  localparam int unsigned CLASSIFY_BUS_CYCLES = 2;
  localparam int unsigned CLASSIFY_OSC_CYCLES =
    CLASSIFY_BUS_CYCLES * OSC_PER_BUS;
  // Reset values
  localparam logic        QUAD_ENABLE_RESET = 1'b1;
  localparam logic        BUS_CLOCK_RESET   = 1'b0;

  typedef enum logic [2:0]
  {
    ST_RUN      = 3'b001,
    ST_DRIVE    = 3'b010,
    ST_CLASSIFY = 3'b100
  } reset_state_e;

endpackage : clock_reset_pkg

// file: core/phase_if.sv
`timescale 1ns/100ps
interface phase_if;
  import clock_reset_pkg::*;

  logic [1:0] phase;
  logic       run;

  modport divider
  (
    output phase,
    input  run
  );
  modport user
  (
    input  phase,
    output run
  );
endinterface : phase_if

// file: core/phase_divider.sv
`timescale 1ns/100ps
module phase_divider
(
  input  wire logic clock,
  input  wire logic rstn,
  phase_if.divider  pif
);
  import clock_reset_pkg::*;

  logic [1:0] phase;
  wire        wrap = (phase == PHASE_LAST);
  wire  [1:0] next_phase = wrap ? PHASE_RESET : phase + 2'h1;

  // Counter holds still while clocks are stopped
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      phase <= PHASE_RESET;
    else if (pif.run)
      phase <= next_phase;
  end

  assign pif.phase = phase;

endmodule : phase_divider

// file: core/clock_reset_pins.sv
`timescale 1ns/100ps
module clock_reset_pins
#(
  parameter int unsigned DRIVE_CYCLES = 4
)
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic osc_input,
  input  wire logic reset_pin_in,
  output logic      reset_pin_out,
  output logic      reset_pin_oe,
  input  wire logic monitor_fail,
  input  wire logic operating_watchdog_fail,
  input  wire logic deep_halt,
  input  wire logic single_chip_mode,
  input  wire logic bus_clock_disable,
  input  wire logic quad_clock_enable_write,
  input  wire logic quad_clock_enable_wdata,
  output logic      bus_clock_out,
  output logic      quad_rate_clock_out,
  output logic      osc_drive_output,
  output logic      quad_clock_enable,
  output logic      init_request,
  output logic      reset_internal,
  output logic      reset_external,
  output logic      data_access,
  output logic      internal_process
);
  import clock_reset_pkg::*;

  // Elaboration check: the drive counter is eight bits wide
  if (DRIVE_CYCLES < 1 || DRIVE_CYCLES > 255)
  begin : g_bad_drive
    $error("DRIVE_CYCLES out of range");
  end

  phase_if pif ();

  phase_divider u_divider
  (
    .clock (clock),
    .rstn  (rstn),
    .pif   (pif.divider)
  );

  reset_state_e state;
  reset_state_e next_state;
  logic [7:0]   count;
  logic [7:0]   next_count;
  logic         osc_prev;

  wire running      = !deep_halt;
  wire osc_rise     = osc_input && !osc_prev;
  wire bus_high     = (pif.phase >= PHASE_HIGH_FROM);
  wire gate_ok      = single_chip_mode && bus_clock_disable;
  wire fail         = monitor_fail || operating_watchdog_fail;
  wire pin_low      = !reset_pin_in;
  wire last_tick    = (count == 8'(CLASSIFY_OSC_CYCLES - 1));
  wire count_end    = last_tick && osc_rise;
  wire drive_end    = (count == 8'(DRIVE_CYCLES - 1));
  wire next_bus     = running && bus_high && !gate_ok;
  wire next_quad    = running && quad_clock_enable && osc_input;
  wire next_drive   = running && !osc_input;
  wire next_access  = running && bus_high;
  wire next_process = running && !bus_high;

  // Divider steps once per oscillator period, so bus rate is osc / 4
  assign pif.run = running && osc_rise;

  // Edge detector starts low, the level of a stopped oscillator
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_input;
  end

  always_comb
  begin
    next_state = state;
    next_count = count + 8'h01;
    case (state)
      ST_RUN:
      begin
        next_count = 8'h00;
        if (fail)
          next_state = ST_DRIVE;
      end
      ST_DRIVE:
      begin
        if (drive_end)
        begin
          next_state = ST_CLASSIFY;
          next_count = 8'h00;
        end
      end
      ST_CLASSIFY:
      begin
        // Window counts oscillator periods: two bus cycles in all
        next_count = osc_rise ? count + 8'h01 : count;
        if (!pin_low || count_end)
        begin
          next_state = ST_RUN;
          next_count = 8'h00;
        end
      end
      default:
      begin
        next_state = ST_RUN;
        next_count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_RUN;
      count <= 8'h00;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  wire drive_now     = (next_state == ST_DRIVE);
  // Release is judged on the first classify cycle onward
  wire quick_release = (state == ST_CLASSIFY) && !pin_low;
  wire slow_release  = (state == ST_CLASSIFY) && count_end && pin_low;
  wire ext_edge      = (state == ST_RUN) && pin_low;
  wire next_external = slow_release || (ext_edge && !fail);

  // Open-drain data is always low; only the enable moves
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reset_pin_out <= 1'b0;
    else
      reset_pin_out <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reset_pin_oe <= 1'b0;
    else
      reset_pin_oe <= drive_now;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      init_request <= 1'b0;
    else
      init_request <= pin_low || drive_now;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reset_internal <= 1'b0;
    else
      reset_internal <= quick_release;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reset_external <= 1'b0;
    else
      reset_external <= next_external;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      quad_clock_enable <= QUAD_ENABLE_RESET;
    else if (quad_clock_enable_write)
      quad_clock_enable <= quad_clock_enable_wdata;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bus_clock_out <= BUS_CLOCK_RESET;
    else
      bus_clock_out <= next_bus;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      quad_rate_clock_out <= 1'b0;
    else
      quad_rate_clock_out <= next_quad;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      osc_drive_output <= 1'b0;
    else
      osc_drive_output <= next_drive;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      data_access <= 1'b0;
    else
      data_access <= next_access;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      internal_process <= 1'b0;
    else
      internal_process <= next_process;
  end

endmodule : clock_reset_pins

// file: dv/clock_reset_pins_monitor.sv
`timescale 1ns/100ps
module clock_reset_pins_monitor
(
  input logic clock,
  input logic rstn,
  input logic osc_input,
  input logic reset_pin_in,
  input logic reset_pin_oe,
  input logic monitor_fail,
  input logic deep_halt,
  input logic single_chip_mode,
  input logic bus_clock_out,
  input logic quad_rate_clock_out,
  input logic quad_clock_enable,
  input logic init_request,
  input logic reset_internal,
  input logic reset_external,
  input logic bus_clock_disable,
  input logic data_access,
  input logic internal_process
);
  wire logic paused = !rstn || deep_halt || single_chip_mode;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_HI: assert property (disable iff (paused) $rose(bus_clock_out)
    |-> bus_clock_out [*4] ##1 !bus_clock_out) else $error("bus high");
  AST_LO: assert property (disable iff (paused) $fell(bus_clock_out)
    |-> !bus_clock_out [*4] ##1 bus_clock_out) else $error("bus low");
  AST_GATE: assert property (!single_chip_mode |=>
    bus_clock_out == data_access) else $error("gate refused");
  AST_GATE_ON: assert property (single_chip_mode && bus_clock_disable
    |=> !bus_clock_out) else $error("gate");
  AST_HALF: assert property (!deep_halt |=>
    data_access != internal_process) else $error("half");
  AST_HALT: assert property (deep_halt [*2] |-> !bus_clock_out &&
    !quad_rate_clock_out) else $error("halt");
  AST_COPY: assert property (quad_clock_enable && !deep_halt |=>
    quad_rate_clock_out == $past(osc_input)) else $error("quad");
  AST_DRIVE: assert property (monitor_fail && !init_request &&
    !reset_pin_oe |=> reset_pin_oe) else $error("drive");
  AST_HOLD: assert property (reset_pin_oe |-> init_request)
    else $error("init");
  AST_INT: assert property ($fell(reset_pin_oe) && reset_pin_in |->
    ##[0:8] reset_internal) else $error("internal");
  AST_EXT: assert property ($fell(reset_pin_in) && !reset_pin_oe |->
    ##[0:24] reset_external) else $error("external");
endmodule : clock_reset_pins_monitor
bind clock_reset_pins clock_reset_pins_monitor u_mon (.*);

// file: dv/reset_partner.sv
`timescale 1ns/100ps
module reset_partner
(
  input  logic reset_pin_oe,
  input  logic hold_low,
  output logic reset_pin_in
);
  // Pulled up unless the device or the reset switch sinks the line
  assign reset_pin_in = !reset_pin_oe && !hold_low;
endmodule : reset_partner

// file: dv/tb_clock_reset_pins.sv
`timescale 1ns/100ps
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, x, y); end end
module tb_clock_reset_pins;
  localparam int DRIVE = 4;
  logic clock = 0, rstn = 0, osc_input = 0, monitor_fail = 0, deep_halt = 0;
  logic operating_watchdog_fail = 0, single_chip_mode = 0, hold_low = 0;
  logic bus_clock_disable = 0, quad_clock_enable_write = 0, reset_pin_out;
  logic quad_clock_enable_wdata = 0, reset_pin_in, internal_process;
  logic reset_pin_oe, bus_clock_out, quad_rate_clock_out, osc_drive_output;
  logic quad_clock_enable, init_request, reset_internal, reset_external;
  logic data_access;
  int   n_fail = 0, n_tests = 0, b, d, h, k, e, o;
  clock_reset_pins #(.DRIVE_CYCLES(DRIVE)) u_dut (.*);
  reset_partner u_far (.*);
  initial forever #5 clock = ~clock;
  always @(posedge clock) osc_input <= #1 ~osc_input;
  task step;
    @(posedge clock);
    #1;
  endtask : step
  // Counts output activity; the switch holds the pin for the first cycles
  task watch(input int n, input int hold);
    {b, d, h, k, e, o} = '0;
    for (int i = 0; i < n; i++)
    begin
      hold_low = i < hold;
      step;
      b += bus_clock_out;
      d += data_access;
      h += init_request;
      k += reset_internal;
      e += reset_external;
      o += reset_pin_oe;
    end
  endtask : watch
  task t_clocks;
    bus_clock_disable = 1;
    watch(16, 0);
    `CHK(b, 8)
    `CHK(d, 8)
    single_chip_mode = 1;
    watch(8, 0);
    `CHK(b, 0)
    // Leave single-chip mode at the start of a low half
    @(negedge data_access);
    #1;
    single_chip_mode = 0;
    // Freeze the divider in its low half
    @(negedge bus_clock_out);
    #1;
    deep_halt = 1;
    watch(6, 0);
    `CHK(b + quad_rate_clock_out, 0)
    deep_halt = 0;
    watch(8, 0);
    `CHK(b, 4)
  endtask : t_clocks
  task t_quad;
    `CHK(quad_clock_enable, 1'b1)
    quad_clock_enable_write = 1;
    step;
    quad_clock_enable_write = 0;
    step;
    `CHK(quad_rate_clock_out | quad_clock_enable, 1'b0)
    {quad_clock_enable_write, quad_clock_enable_wdata} = 2'h3;
    step;
    quad_clock_enable_write = 0;
    step;
    o = quad_rate_clock_out;
    step;
    `CHK(quad_rate_clock_out, !o)
    `CHK(osc_drive_output, !quad_rate_clock_out)
  endtask : t_quad
  task t_fail(input logic wd);
    {monitor_fail, operating_watchdog_fail} = {!wd, wd};
    step;
    {monitor_fail, operating_watchdog_fail} = 2'h0;
    `CHK(reset_pin_oe & init_request, 1'b1)
    `CHK(reset_pin_out, 1'b0)
    watch(16, 0);
    `CHK(o, DRIVE - 1)
    `CHK(k > 0 && e == 0, 1'b1)
  endtask : t_fail
  task t_ext;
    watch(32, 12);
    `CHK(h >= 12 && o == 0, 1'b1)
    `CHK(e > 0 && k == 0, 1'b1)
  endtask : t_ext
  // Switch still held when the device lets go: classified external
  task t_slow;
    hold_low = 1;
    monitor_fail = 1;
    step;
    monitor_fail = 0;
    watch(40, 30);
    `CHK(k, 0)
    `CHK(e > 0 && h >= 30, 1'b1)
  endtask : t_slow
  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (8) step;
    rstn = 1;
    t_quad;
    t_clocks;
    t_fail(0);
    t_fail(1);
    t_ext;
    t_slow;
    report_and_stop;
  end
  initial
  begin
    #5000;
    n_fail++;
    report_and_stop;
  end
endmodule : tb_clock_reset_pins
